// ==== iodr_defs.vh ====
// Constants for the ISA I/O decode and interrupt routing block.
`ifndef IODR_DEFS_VH
`define IODR_DEFS_VH
`define IODR_ADDR_W        10
`define IODR_BASE_LSB      2
`define IODR_BASE_MSB      9
`define IODR_BASE_W        8
`define IODR_BASE_DEFAULT  8'hC0
`define IODR_SW_DEFAULT    8'h3F
`define IODR_ROUTE_W       4
`define IODR_ROUTE_NONE    4'h0
`define IODR_ROUTE_IRQ5    4'h1
`define IODR_ROUTE_IRQ6    4'h2
`define IODR_ROUTE_IRQ9    4'h3
`define IODR_ROUTE_IRQ10   4'h4
`define IODR_ROUTE_IRQ11   4'h5
`define IODR_ROUTE_IRQ12   4'h6
`define IODR_ROUTE_IRQ14   4'h7
`define IODR_ROUTE_IRQ15   4'h8
`define IODR_IRQ_LINES     8
`define IODR_SETTLE_CNT    3'h4
`endif

// ==== iodr_host.sv ====
// Host processor model driving ISA I/O cycles.
`timescale 1ns/1ns
module iodr_host (output reg [15:0] isa_addr_out = 16'h0000,
   output reg isa_aen_out = 1'b1, isa_ior_n_out = 1'b1, isa_iow_n_out = 1'b1);
   // Any address, AEN level and strobe pair is driven at once, with no bus timing; the caller paces each cycle.
   task drive(input [15:0] ad, input [1:0] kd, input ae);
      isa_addr_out = ad;
      isa_aen_out = ae;
      isa_ior_n_out = !kd[0];
      isa_iow_n_out = !kd[1];
   endtask
endmodule // iodr_host

// ==== iodr_props.sv ====
// Port checker of decode and interrupt routing.
`timescale 1ns/1ns
module iodr_props (input wire clk_in, rst_in, isa_aen_in, isa_ior_n_in, isa_iow_n_in, irq_pending_in,
   card_sel_out, rd_sel_out, wr_sel_out, input wire [15:0] isa_addr_in, input wire [7:0] io_base_switch_closed_in,
   irq_line_out, irq_oe_out, input wire [3:0] interrupt_route_strap_in, input wire [1:0] reg_loc_out);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   chk_sel_decode: assert property (card_sel_out |-> !$past(isa_aen_in) &&
      $past(isa_addr_in[9:2]) == ~io_base_switch_closed_in) else $error("sel");
   chk_loc_follow: assert property (card_sel_out |-> reg_loc_out == $past(isa_addr_in[1:0])) else $error("loc");
   chk_rd_qual: assert property (rd_sel_out == (card_sel_out && !$past(isa_ior_n_in))) else $error("rd");
   chk_wr_qual: assert property (wr_sel_out == (card_sel_out && !$past(isa_iow_n_in))) else $error("wr");
   chk_oe_single: assert property ($onehot0(irq_oe_out)) else $error("oe");
   chk_none_quiet: assert property (interrupt_route_strap_in inside {4'h0, [4'h9:4'hF]} |-> !irq_oe_out)
      else $error("park");
   chk_irq_hold: assert property ($past(irq_pending_in) && |irq_oe_out |-> irq_line_out == irq_oe_out)
      else $error("hold");
   chk_irq_release: assert property (!$past(irq_pending_in) |-> !irq_line_out) else $error("rel");
   cover property (rd_sel_out);
   cover property (wr_sel_out);
   cover property (|irq_line_out);
endmodule // iodr_props
bind iodr_top iodr_props u_props (.*);

// ==== iodr_sync.v ====
// Three-stage synchroniser with agreement filter for one asynchronous input.
`timescale 1ns/1ns
module iodr_sync #(
   parameter       W     = 1,
   parameter [W-1:0] INIT = {W{1'b0}}
) (
   input  wire         clk_in,
   input  wire         rst_in,
   input  wire         ce_in,
   input  wire [W-1:0] d_in,
   output wire [W-1:0] q_out
);
   reg [W-1:0] s1_q;
   reg [W-1:0] s2_q;
   reg [W-1:0] s3_q;
   reg [W-1:0] val_q;
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         s1_q  <= INIT;
         s2_q  <= INIT;
         s3_q  <= INIT;
         val_q <= INIT;
      end else if (ce_in) begin
         s1_q <= d_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         // A change counts only once the last two stages agree.
         if (s2_q == s3_q) begin
            val_q <= s3_q;
         end
      end
   end
   assign q_out = val_q;
endmodule // iodr_sync

// ==== iodr_top.v ====
// ISA I/O address decoder and interrupt request router of the bus card.
// Contract
// - Card occupies four consecutive I/O bytes holding two 16-bit registers.
// - Decode only I/O range up to 3FFH; ignore address bits 10 to 15.
// - Select when address bits 9..2 equal base; bits 1..0 pick location.
// - Base switch element reads one when open, zero when closed.
// - Factory base setting places the card at 300H.
// - Interrupt routed by strap to one of IRQ 5,6,9,10,11,12,14,15.
// - Default strap routes the interrupt to IRQ10.
// - Strap removed or parked: no host interrupt line is driven.
`timescale 1ns/1ns
`include "iodr_defs.vh"
module iodr_top (
   input  wire                     clk_in,
   input  wire                     rst_in,
   input  wire                     ce_in,
   input  wire [15:0]              isa_addr_in,
   input  wire                     isa_aen_in,
   input  wire                     isa_ior_n_in,
   input  wire                     isa_iow_n_in,
   input  wire [`IODR_BASE_W-1:0]  io_base_switch_closed_in,
   input  wire [`IODR_ROUTE_W-1:0] interrupt_route_strap_in,
   input  wire                     irq_pending_in,
   output reg                      card_sel_out,
   output reg  [1:0]               reg_loc_out,
   output reg                      rd_sel_out,
   output reg                      wr_sel_out,
   output reg  [7:0]               irq_line_out,
   output reg  [7:0]               irq_oe_out
);
   wire [`IODR_BASE_W-1:0]  sw_sync;
   wire [`IODR_ROUTE_W-1:0] strap_sync;
   reg  [`IODR_BASE_W-1:0]  base_q;
   reg  [`IODR_ROUTE_W-1:0] route_q;
   reg                      cap_done_q;
   reg  [2:0]               settle_q;
   wire                     hit;
   wire [7:0]               route_onehot;

   // Switch elements are pins from outside the clock domain.
   iodr_sync #(.W(`IODR_BASE_W), .INIT(`IODR_SW_DEFAULT)) u_sw_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (io_base_switch_closed_in),
      .q_out  (sw_sync)
   );

   iodr_sync #(.W(`IODR_ROUTE_W), .INIT(`IODR_ROUTE_IRQ10)) u_strap_sync (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .ce_in  (ce_in),
      .d_in   (interrupt_route_strap_in),
      .q_out  (strap_sync)
   );

   // Map a strap code onto one of the eight host request lines.
   function [7:0] route_decode;
      input [`IODR_ROUTE_W-1:0] code;
      begin
         case (code)
            `IODR_ROUTE_IRQ5:  route_decode = 8'h01;
            `IODR_ROUTE_IRQ6:  route_decode = 8'h02;
            `IODR_ROUTE_IRQ9:  route_decode = 8'h04;
            `IODR_ROUTE_IRQ10: route_decode = 8'h08;
            `IODR_ROUTE_IRQ11: route_decode = 8'h10;
            `IODR_ROUTE_IRQ12: route_decode = 8'h20;
            `IODR_ROUTE_IRQ14: route_decode = 8'h40;
            `IODR_ROUTE_IRQ15: route_decode = 8'h80;
            default:           route_decode = 8'h00;
         endcase
      end
   endfunction

   // Straps are caught after reset release; a switch closed reads as zero.
   // Settings are latched once so a bumped switch cannot move the card live.
   // Capture waits until the synchronisers have passed the real pin level,
   // otherwise their reset value would be latched instead of the switches.
   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         base_q     <= `IODR_BASE_DEFAULT;
         route_q    <= `IODR_ROUTE_IRQ10;
         cap_done_q <= 1'b0;
         settle_q   <= 3'h0;
      end else if (ce_in && !cap_done_q) begin
         if (settle_q == `IODR_SETTLE_CNT) begin
            base_q     <= ~sw_sync;
            route_q    <= strap_sync;
            cap_done_q <= 1'b1;
         end else begin
            settle_q <= settle_q + 3'h1;
         end
      end
   end

   // Bits 15..10 never enter the compare, so the card aliases every 1K.
   assign hit = !isa_aen_in &&
                (isa_addr_in[`IODR_BASE_MSB:`IODR_BASE_LSB] == base_q);

   assign route_onehot = route_decode(route_q);

   always @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         card_sel_out <= 1'b0;
         reg_loc_out  <= 2'h0;
         rd_sel_out   <= 1'b0;
         wr_sel_out   <= 1'b0;
         irq_line_out <= 8'h00;
         irq_oe_out   <= 8'h00;
      end else if (ce_in) begin
         card_sel_out <= hit && cap_done_q;
         reg_loc_out  <= isa_addr_in[1:0];
         rd_sel_out   <= hit && cap_done_q && !isa_ior_n_in;
         wr_sel_out   <= hit && cap_done_q && !isa_iow_n_in;
         // Only the routed line is driven; the others stay released for other cards.
         irq_oe_out   <= cap_done_q ? route_onehot : 8'h00;
         irq_line_out <= (cap_done_q && irq_pending_in) ? route_onehot : 8'h00;
      end
   end
endmodule // iodr_top

// ==== iodr_top_tb.sv ====
// Bench for the decode and interrupt routing block.
`timescale 1ns/1ns
module iodr_top_tb;
   reg clk_in = 0, rst_in = 1, irq_pending_in = 0, m;
   reg [7:0] io_base_switch_closed_in = 8'h3F, e;
   reg [3:0] interrupt_route_strap_in = 4'h4;
   wire [15:0] isa_addr_in;
   wire isa_aen_in, isa_ior_n_in, isa_iow_n_in, card_sel_out, rd_sel_out, wr_sel_out;
   wire [1:0] reg_loc_out;
   wire [7:0] irq_line_out, irq_oe_out, b = ~io_base_switch_closed_in;
   integer fail_count = 0, num_checks = 0, c, k, a;
   iodr_top DUT (.*, .ce_in(1'b1));
   iodr_host host (.isa_addr_out(isa_addr_in), .isa_aen_out(isa_aen_in), .isa_ior_n_out(isa_ior_n_in),
      .isa_iow_n_out(isa_iow_n_in));
   initial forever #5 clk_in = ~clk_in;
   task check(input [15:0] s, input [15:0] x);
      num_checks++;
      if (s !== x) begin
         fail_count++;
         $display("[FAIL] %0t seen %h exp %h", $time, s, x);
      end
   endtask
   task close_out;
      $display("%0d checks %0d fails", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Strobes are released with the address inverted, so a stale address never looks held.
   task acc(input [15:0] ad, input [1:0] kd, input ae);
      m = ad[9:2] == b && !ae;
      host.drive(ad, kd, ae);
      @(negedge clk_in);
      check({card_sel_out, rd_sel_out, wr_sel_out, reg_loc_out & {2{m}}}, {m, m & kd[0], m & kd[1], ad[1:0] & {2{m}}});
      host.drive(~ad, 2'b00, ~ae);
      @(negedge clk_in);
   endtask
   initial begin
      a = $urandom(32'hfdb7);
      for (c = 0; c < 17; c++) begin
         @(negedge clk_in);
         rst_in = 1;
         io_base_switch_closed_in = c ? $urandom : 8'h3F;
         interrupt_route_strap_in = c ? c - 1 : 4'h4;
         repeat (12) @(negedge clk_in);
         rst_in = 0;
         repeat (17) @(negedge clk_in);
         for (k = 0; k < 4; k++) begin
            a = $urandom;
            acc({a[15:10], b, k[1:0]}, 1, 0);
            acc({a[15:10], b, k[1:0]}, 2, 0);
            acc({a[15:10], b ^ (8'h01 << a[2:0]), k[1:0]}, 1, 0);
            acc({a[15:10], b, k[1:0]}, 2, 1);
            acc(a[15:0], a[17:16], a[18]);
         end
         e = (interrupt_route_strap_in inside {[1:8]}) ? 8'h01 << (interrupt_route_strap_in - 1) : 8'h00;
         irq_pending_in = 1;
         repeat (3) @(negedge clk_in) check({irq_line_out, irq_oe_out}, {e, e});
         irq_pending_in = 0;
         @(negedge clk_in) check({irq_line_out, irq_oe_out}, {8'h00, e});
      end
      close_out;
   end
   initial begin
      #100000 fail_count++;
      close_out;
   end
endmodule // iodr_top_tb
